/* File: hdl/ccr_addr_crc.v */
// Fixed 64-bit device address with its check byte.
// Assumes family code and serial number are constants.
`timescale 1ns/1ps
`include "ccr_map.vh"

module ccr_addr_crc #(
    parameter [7:0]  FAMILY = `CCR_FAMILY_CODE,
    parameter [47:0] SERIAL = `CCR_SERIAL_NUMBER
) (
    // Address
    output wire [63:0] dev_address
);

    // ****************************************
    // Check byte over 56 bits, low bit first
    // ****************************************
    function [7:0] crc56;
        input [55:0] data;
        integer i;
        reg [7:0] c;
        reg       fb;
        begin
            c = 8'h00;
            for (i = 0; i < 56; i = i + 1) begin
                fb = c[0] ^ data[i];
                c  = {1'b0, c[7:1]};
                if (fb) begin
                    c = c ^ 8'h8C;
                end
            end
            crc56 = c;
        end
    endfunction

    assign dev_address = {crc56({SERIAL, FAMILY}), SERIAL, FAMILY};

endmodule

/* File: hdl/ccr_map.vh */
// Register map, field positions, reset values and timing for the charge counter.
// Assumes a single 50 MHz system clock; times are given in milliseconds.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define CCR_ADDR_STATUS      8'h01
`define CCR_ADDR_PIN         8'h08
`define CCR_ADDR_CUR_HI      8'h0E
`define CCR_ADDR_CUR_LO      8'h0F
`define CCR_ADDR_ACC_HI      8'h10
`define CCR_ADDR_ACC_LO      8'h11

// ****************************************
// Field positions and values
// ****************************************
`define CCR_BIT_SLEEP_EN     6
`define CCR_BIT_OPCODE_SEL   4
`define CCR_BIT_PIN          6
`define CCR_OPCODE_ADDR_A    8'h33
`define CCR_OPCODE_ADDR_B    8'h39
`define CCR_RESERVED_READ    8'h00
`define CCR_RST_SLEEP_EN     1'b0
`define CCR_RST_OPCODE_SEL   1'b0
`define CCR_RST_PIN          1'b1

// ****************************************
// Conversion, accumulation and device address
// ****************************************
`define CCR_OFFSET_EVERY     1024
`define CCR_FRAC_BITS        12
`define CCR_FAMILY_CODE      8'h5A
`define CCR_SERIAL_NUMBER    48'h0000_0000_0001

// ****************************************
// Timing
// ****************************************
`define CCR_CLK_KHZ          50000
`define CCR_CONV_HI_MS       3500
`define CCR_CONV_LO_MS       875
`define CCR_SLEEP_DELAY_MS   2000
`define CCR_CONV_HI_CYC      (`CCR_CONV_HI_MS * `CCR_CLK_KHZ)
`define CCR_CONV_LO_CYC      (`CCR_CONV_LO_MS * `CCR_CLK_KHZ)
`define CCR_SLEEP_DELAY_CYC  (`CCR_SLEEP_DELAY_MS * `CCR_CLK_KHZ)

`endif

/* File: hdl/ccr_regs.v */
// Charge counter register bank: current result, offset slots, accumulator,
// control bits and byte latching for the serial register port.
// Assumes the serial link logic gives byte strobes; analog side gives raw results.
`timescale 1ns/1ps
`include "ccr_map.vh"

module ccr_regs #(
    parameter HIGH_RES    = 1,
    parameter CONV_CYC    = HIGH_RES ? `CCR_CONV_HI_CYC : `CCR_CONV_LO_CYC,
    parameter SLEEP_CYC   = `CCR_SLEEP_DELAY_CYC,
    parameter OFFSET_EVERY = `CCR_OFFSET_EVERY
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Register port
    input  wire        cmd_addr_load,
    input  wire [7:0]  cmd_addr,
    input  wire        rd_stb,
    input  wire        wr_stb,
    input  wire [7:0]  wr_data,
    input  wire        cmd_end,
    output reg  [7:0]  rd_data,
    // Converter
    input  wire [15:0] adc_result,
    output reg         adc_offset_sel,
    output reg         conv_done,
    // Power
    input  wire        supply_low,
    input  wire        bus_line_in,
    output reg         sleep_mode,
    // Link control
    output reg  [7:0]  addr_read_opcode,
    output reg  [63:0] net_address,
    // General open-drain pin
    input  wire        pio_pin_in,
    output reg         pio_drive_out,
    output reg         pio_drive_oe_n
);

    localparam FB = `CCR_FRAC_BITS;
    localparam AW = 16 + FB;

    reg  [7:0]    ptr_reg;
    reg           sleep_enable_bit_reg;
    reg           opcode_sel_reg;
    reg           pin_ctrl_reg;
    reg           pin_ctrl_next;
    reg  [15:0]   offset_reg;
    reg  [15:0]   current_reg;
    reg  [AW-1:0] acc_reg;
    reg  [AW-1:0] acc_next;
    reg  [9:0]    conv_cnt_reg;
    reg           force_offset_reg;
    reg           cur_lat_valid_reg;
    reg  [7:0]    cur_lat_lo_reg;
    reg           acc_lat_valid_reg;
    reg  [7:0]    acc_lat_lo_reg;
    reg           sleep_next;
    wire          conv_tick;
    wire          conv_tick_raw;
    wire          bus_low_tick;
    wire [63:0]   dev_address;
    wire [15:0]   raw_diff;
    wire [15:0]   corrected;
    wire          wr_acc_hi;
    wire          wr_acc_lo;
    wire          offset_slot;

    // ****************************************
    // Helpers
    // ****************************************
    function [AW-1:0] sext_cur;
        input [15:0] v;
        begin
            sext_cur = {{(AW-16){v[15]}}, v};
        end
    endfunction

    function wr_hit;
        input [7:0] a;
        begin
            wr_hit = wr_stb && (ptr_reg == a);
        end
    endfunction

    function [7:0] opcode_of;
        input sel;
        begin
            opcode_of = sel ? `CCR_OPCODE_ADDR_B : `CCR_OPCODE_ADDR_A;
        end
    endfunction

    function [7:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `CCR_ADDR_STATUS: read_mux = {1'b0, sleep_enable_bit_reg, 1'b0,
                                              opcode_sel_reg, 4'h0};
                `CCR_ADDR_PIN:    read_mux = {1'b0, pio_pin_in, 6'h00};
                `CCR_ADDR_CUR_HI: read_mux = current_reg[15:8];
                `CCR_ADDR_CUR_LO: read_mux = cur_lat_valid_reg ? cur_lat_lo_reg
                                                               : current_reg[7:0];
                `CCR_ADDR_ACC_HI: read_mux = acc_reg[AW-1:AW-8];
                `CCR_ADDR_ACC_LO: read_mux = acc_lat_valid_reg ? acc_lat_lo_reg
                                                               : acc_reg[AW-9:FB];
                default:          read_mux = `CCR_RESERVED_READ;
            endcase
        end
    endfunction

    // ****************************************
    // Sub blocks
    // ****************************************
    ccr_timebase #(
        .PERIOD  (CONV_CYC)
    ) u_conv_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (!sleep_mode),
        .restart (1'b0),
        .tick    (conv_tick_raw)
    );

    ccr_timebase #(
        .PERIOD  (SLEEP_CYC)
    ) u_bus_low_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (!bus_line_in),
        .restart (bus_line_in),
        .tick    (bus_low_tick)
    );

    ccr_addr_crc u_addr (
        .dev_address (dev_address)
    );

    // ****************************************
    // Conversion arithmetic
    // ****************************************
    assign conv_tick = conv_tick_raw && !sleep_mode;
    assign raw_diff  = adc_result - offset_reg;
    assign corrected = HIGH_RES ? raw_diff
                                : {{2{raw_diff[15]}}, raw_diff[15:2]};
    assign offset_slot = force_offset_reg
                         || (conv_cnt_reg == OFFSET_EVERY - 1);
    assign wr_acc_hi = wr_hit(`CCR_ADDR_ACC_HI);
    assign wr_acc_lo = wr_hit(`CCR_ADDR_ACC_LO);

    // ****************************************
    // Accumulator next value
    // ****************************************
    always @* begin
        acc_next = acc_reg;
        if (wr_acc_hi) begin
            acc_next = {wr_data, acc_reg[AW-9:FB], {FB{1'b0}}};
        end else if (wr_acc_lo) begin
            acc_next = {acc_reg[AW-1:AW-8], wr_data, {FB{1'b0}}};
        end else if (conv_tick && !force_offset_reg) begin
            if (offset_slot) begin
                acc_next = acc_reg + sext_cur(current_reg);
            end else begin
                acc_next = acc_reg + sext_cur(corrected);
            end
        end
    end

    // ****************************************
    // Power mode and pin control next values
    // ****************************************
    always @* begin
        sleep_next    = sleep_mode;
        pin_ctrl_next = pin_ctrl_reg;
        if (wr_hit(`CCR_ADDR_PIN)) begin
            pin_ctrl_next = wr_data[`CCR_BIT_PIN];
        end
        if (!sleep_mode) begin
            if (supply_low || (sleep_enable_bit_reg && bus_low_tick)) begin
                sleep_next    = 1'b1;
                pin_ctrl_next = 1'b1;
            end
        end else if (bus_line_in && !supply_low) begin
            sleep_next = 1'b0;
        end
        if (bus_low_tick) begin
            pin_ctrl_next = 1'b1;
        end
    end

    // ****************************************
    // Registers and measurement
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ptr_reg              <= 8'h00;
            sleep_enable_bit_reg <= `CCR_RST_SLEEP_EN;
            opcode_sel_reg       <= `CCR_RST_OPCODE_SEL;
            pin_ctrl_reg         <= `CCR_RST_PIN;
            offset_reg           <= 16'h0000;
            current_reg          <= 16'h0000;
            acc_reg              <= {AW{1'b0}};
            conv_cnt_reg         <= 10'h000;
            force_offset_reg     <= 1'b0;
            cur_lat_valid_reg    <= 1'b0;
            cur_lat_lo_reg       <= 8'h00;
            acc_lat_valid_reg    <= 1'b0;
            acc_lat_lo_reg       <= 8'h00;
            rd_data              <= 8'h00;
            adc_offset_sel       <= 1'b0;
            conv_done            <= 1'b0;
            sleep_mode           <= 1'b0;
            addr_read_opcode     <= `CCR_OPCODE_ADDR_A;
            net_address          <= 64'h0;
            pio_drive_out        <= 1'b0;
            pio_drive_oe_n       <= 1'b1;
        end else begin
            net_address    <= dev_address;
            sleep_mode     <= sleep_next;
            pin_ctrl_reg   <= pin_ctrl_next;
            pio_drive_out  <= 1'b0;
            pio_drive_oe_n <= pin_ctrl_next;
            acc_reg        <= acc_next;
            addr_read_opcode <= opcode_of(opcode_sel_reg);
            conv_done      <= conv_tick;
            adc_offset_sel <= offset_slot;
            // ****************************************
            // Address pointer
            // ****************************************
            if (cmd_addr_load) begin
                ptr_reg <= cmd_addr;
            end else if (rd_stb || wr_stb) begin
                ptr_reg <= ptr_reg + 8'h01;
            end
            // ****************************************
            // Reads and two-byte latching
            // ****************************************
            if (cmd_end || cmd_addr_load) begin
                cur_lat_valid_reg <= 1'b0;
                acc_lat_valid_reg <= 1'b0;
            end else if (rd_stb) begin
                rd_data <= read_mux(ptr_reg);
                if (ptr_reg == `CCR_ADDR_CUR_HI) begin
                    cur_lat_valid_reg <= 1'b1;
                    cur_lat_lo_reg    <= current_reg[7:0];
                end
                if (ptr_reg == `CCR_ADDR_ACC_HI) begin
                    acc_lat_valid_reg <= 1'b1;
                    acc_lat_lo_reg    <= acc_reg[AW-9:FB];
                end
            end
            // ****************************************
            // Status control writes; pin and accumulator writes are handled above
            // ****************************************
            if (wr_hit(`CCR_ADDR_STATUS)) begin
                sleep_enable_bit_reg <= wr_data[`CCR_BIT_SLEEP_EN];
                opcode_sel_reg       <= wr_data[`CCR_BIT_OPCODE_SEL];
            end
            // ****************************************
            // Conversion slots
            // ****************************************
            if (wr_acc_hi || wr_acc_lo) begin
                force_offset_reg <= 1'b1;
            end else if (conv_tick) begin
                if (offset_slot) begin
                    offset_reg       <= adc_result;
                    conv_cnt_reg     <= 10'h000;
                    force_offset_reg <= 1'b0;
                end else begin
                    current_reg  <= corrected;
                    conv_cnt_reg <= conv_cnt_reg + 10'h001;
                end
            end
        end
    end

endmodule

/* File: hdl/ccr_timebase.v */
// Period divider with run enable and restart giving a one-cycle tick.
// Assumes synchronous active-low reset and one clock.
`timescale 1ns/1ps

module ccr_timebase #(
    parameter PERIOD = 1000
) (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // Control
    input  wire run,
    input  wire restart,
    // Tick
    output reg  tick
);

    reg [31:0] count_reg;

    // ****************************************
    // Counter
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst_n || restart) begin
            count_reg <= 32'h0;
            tick      <= 1'b0;
        end else if (run) begin
            if (count_reg == PERIOD - 1) begin
                count_reg <= 32'h0;
                tick      <= 1'b1;
            end else begin
                count_reg <= count_reg + 32'h1;
                tick      <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule

/* File: test/ccr_assertions.sv */
// Port checks for the charge counter register bank.
// Assumes bind into ccr_regs, one clock, synchronous active-low reset.
`timescale 1ns/1ps

module ccr_assertions #(
    parameter SLEEP_CYC = 30
) (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Register port
    input wire       cmd_addr_load,
    input wire [7:0] cmd_addr,
    input wire       wr_stb,
    input wire [7:0] wr_data,
    // Conversion, power and pin
    input wire       conv_done,
    input wire       supply_low,
    input wire       bus_line_in,
    input wire       sleep_mode,
    input wire [7:0] addr_read_opcode,
    input wire       pio_drive_oe_n
);
    // ****************************************
    // Bus low counter and properties
    // ****************************************
    integer low_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always @(posedge clk_sys) begin
        if (!rst_n || bus_line_in) begin
            low_cnt <= 0;
        end else if (low_cnt < SLEEP_CYC + 8) begin
            low_cnt <= low_cnt + 1;
        end
    end
    property p_opcode;
        logic b;
        (cmd_addr_load && cmd_addr == 8'h01 ##1 (wr_stb, b = wr_data[4]))
            |-> ##2 addr_read_opcode == (b ? 8'h39 : 8'h33);
    endproperty
    AST_OPCODE_SEL: assert property (p_opcode)
        else $error("opcode select wrong");
    AST_RESET_STATE: assert property ($rose(rst_n) |-> addr_read_opcode == 8'h33
        && pio_drive_oe_n && !sleep_mode) else $error("reset state wrong");
    AST_PIN_DRIVE: assert property ($fell(pio_drive_oe_n) |-> $past(wr_stb)
        || $past(wr_stb, 2)) else $error("pin driven without write");
    AST_CONV_PULSE: assert property (conv_done |=> !conv_done)
        else $error("conversion pulse too long");
    AST_SLEEP_QUIET: assert property (sleep_mode && $past(sleep_mode) |-> !conv_done)
        else $error("conversion in sleep");
    AST_SUPPLY_SLEEP: assert property (supply_low [*2] |-> sleep_mode)
        else $error("no sleep on undervoltage");
    AST_WAKE: assert property ((bus_line_in && !supply_low) [*3] |-> !sleep_mode)
        else $error("no wake");
    AST_BUS_LOW_PIN: assert property (low_cnt == SLEEP_CYC + 3 |-> pio_drive_oe_n)
        else $error("pin not released on bus low");
    AST_SLEEP_PIN: assert property ($rose(sleep_mode) |-> ##[0:2] pio_drive_oe_n)
        else $error("pin not released on sleep");
    cover property (conv_done);
    cover property ($rose(sleep_mode));
    cover property (!pio_drive_oe_n);
endmodule

bind ccr_regs ccr_assertions #(.SLEEP_CYC(SLEEP_CYC)) ccr_assertions_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_addr_load(cmd_addr_load),
    .cmd_addr(cmd_addr), .wr_stb(wr_stb), .wr_data(wr_data), .conv_done(conv_done),
    .supply_low(supply_low), .bus_line_in(bus_line_in), .sleep_mode(sleep_mode),
    .addr_read_opcode(addr_read_opcode), .pio_drive_oe_n(pio_drive_oe_n));

/* File: test/ccr_host_model.sv */
// Host side register master for the charge counter bench.
// Assumes calls are made just after a rising clk_sys edge.
`timescale 1ns/1ps

module ccr_host_model (
    // Clock
    input wire       clk_sys,
    // Register port
    output reg       cmd_addr_load,
    output reg [7:0] cmd_addr,
    output reg       rd_stb,
    output reg       wr_stb,
    output reg [7:0] wr_data,
    output reg       cmd_end,
    input wire [7:0] rd_data
);
    // ****************************************
    // Port steps
    // ****************************************
    initial begin
        {cmd_addr_load, rd_stb, wr_stb, cmd_end} = 4'h0;
        cmd_addr = 8'h00;
        wr_data = 8'h00;
    end
    // One clock; unused lines toggle
    task step(input l, input r, input w, input e, input [7:0] v);
        begin
            cmd_addr_load = l;
            rd_stb = r;
            wr_stb = w;
            cmd_end = e;
            cmd_addr = l ? v : ~cmd_addr;
            wr_data = w ? v : ~wr_data;
            @(posedge clk_sys);
            #1;
        end
    endtask
    // Both bytes in one command
    task rd_pair(input [7:0] a, output [7:0] hi, output [7:0] lo);
        begin
            step(1, 0, 0, 0, a);
            step(0, 1, 0, 0, 8'h00);
            hi = rd_data;
            step(0, 1, 0, 0, 8'h00);
            lo = rd_data;
            step(0, 0, 0, 1, 8'h00);
        end
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the charge counter register bank.
// Assumes ccr_regs, ccr_host_model and the bound checker are compiled.
`timescale 1ns/1ps

module testbench;
    // ****************************************
    // Signals, instances, tasks
    // ****************************************
    localparam SLP = 30;
    localparam NOFF = 8;
    reg         clk_sys;
    reg         rst_n;
    reg  [15:0] adc_result;
    reg         supply_low;
    reg         bus_line_in;
    reg         pin_pull;
    reg  [7:0]  hi;
    reg  [7:0]  lo;
    integer     bad_count = 0;
    integer     num_checks = 0;
    wire        cmd_addr_load, rd_stb, wr_stb, cmd_end, conv_done, sleep_mode, oe_n;
    wire [7:0]  cmd_addr, wr_data, rd_data, opcode;
    wire        offset_sel, drive_out;
    wire [63:0] net_addr;
    wire        pio_pin_in = oe_n ? pin_pull : 1'b0;

    ccr_regs #(.CONV_CYC(20), .SLEEP_CYC(SLP), .OFFSET_EVERY(NOFF)) ccr_regs_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_addr_load(cmd_addr_load),
        .cmd_addr(cmd_addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
        .cmd_end(cmd_end), .rd_data(rd_data), .adc_result(adc_result),
        .adc_offset_sel(offset_sel), .conv_done(conv_done), .supply_low(supply_low),
        .bus_line_in(bus_line_in), .sleep_mode(sleep_mode), .addr_read_opcode(opcode),
        .net_address(net_addr), .pio_pin_in(pio_pin_in), .pio_drive_out(drive_out),
        .pio_drive_oe_n(oe_n));
    ccr_host_model ccr_host_model_inst (
        .clk_sys(clk_sys), .cmd_addr_load(cmd_addr_load), .cmd_addr(cmd_addr),
        .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .cmd_end(cmd_end),
        .rd_data(rd_data));

    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    task st(input l, input r, input w, input e, input [7:0] v);
        ccr_host_model_inst.step(l, r, w, e, v);
    endtask
    task rd(input [7:0] a);
        ccr_host_model_inst.rd_pair(a, hi, lo);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            st(1, 0, 0, 0, a);
            st(0, 0, 1, 0, d);
            st(0, 0, 0, 1, 8'h00);
        end
    endtask
    task wait_conv;
        integer i;
        begin
            i = 0;
            do begin
                st(0, 0, 0, 0, 8'h00);
                i = i + 1;
            end while (conv_done !== 1'b1 && i < 80);
            chk("conv_done", 8'h01, {7'h00, conv_done});
        end
    endtask
    task cur_acc(input [15:0] c, input [15:0] a);
        begin
            rd(8'h0E);
            chk("current", c[15:8], hi);
            chk("current", c[7:0], lo);
            rd(8'h10);
            chk("charge", a[15:8], hi);
            chk("charge", a[7:0], lo);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs;
        begin
            rd(8'h01);
            chk("status", 8'h00, hi);
            chk("family", 8'h5A, net_addr[7:0]);
            chk("serial", 8'h01, net_addr[15:8]);
            rd(8'h08);
            chk("pin", 8'h40, hi);
            wr(8'h01, 8'h10);
            st(1, 0, 0, 0, 8'hFF);
            repeat (3) st(0, 1, 0, 0, 8'h00);
            chk("wrap", 8'h10, rd_data);
            st(0, 0, 0, 1, 8'h00);
            chk("opcode", 8'h39, opcode);
            wr(8'h01, 8'hFF);
            rd(8'h01);
            chk("status", 8'h50, hi);
            wr(8'h01, 8'h00);
            chk("opcode", 8'h33, opcode);
            wr(8'h05, 8'hFF);
            wr(8'h0E, 8'hFF);
            rd(8'h05);
            chk("reserved", 8'h00, hi);
            rd(8'h0E);
            chk("current", 8'h00, hi);
        end
    endtask
    task t_pin;
        begin
            wr(8'h08, 8'h00);
            chk("oe_n", 8'h00, {7'h00, oe_n});
            chk("drive", 8'h00, {7'h00, drive_out});
            rd(8'h08);
            chk("pin", 8'h00, hi);
            wr(8'h08, 8'hFF);
            pin_pull = 1'b0;
            rd(8'h08);
            chk("pin", 8'h00, hi);
            pin_pull = 1'b1;
            rd(8'h08);
            chk("pin", 8'h40, hi);
        end
    endtask
    task t_sleep;
        integer n;
        begin
            wr(8'h08, 8'h00);
            bus_line_in = 1'b0;
            repeat (SLP + 8) st(0, 0, 0, 0, 8'h00);
            chk("sleep", 8'h00, {7'h00, sleep_mode});
            chk("oe_n", 8'h01, {7'h00, oe_n});
            bus_line_in = 1'b1;
            wr(8'h01, 8'h40);
            wr(8'h08, 8'h00);
            bus_line_in = 1'b0;
            repeat (SLP + 8) st(0, 0, 0, 0, 8'h00);
            chk("sleep", 8'h01, {7'h00, sleep_mode});
            n = 0;
            repeat (60) begin
                st(0, 0, 0, 0, 8'h00);
                n = n + conv_done;
            end
            chk("conv_sleep", 8'h00, n[7:0]);
            rd(8'h01);
            chk("status", 8'h40, hi);
            bus_line_in = 1'b1;
            wr(8'h01, 8'h00);
            chk("sleep", 8'h00, {7'h00, sleep_mode});
            supply_low = 1'b1;
            repeat (3) st(0, 0, 0, 0, 8'h00);
            chk("sleep", 8'h01, {7'h00, sleep_mode});
            supply_low = 1'b0;
            repeat (3) st(0, 0, 0, 0, 8'h00);
        end
    endtask
    task t_conv;
        begin
            adc_result = 16'h0C00;
            wait_conv;
            wait_conv;
            adc_result = 16'h0100;
            wr(8'h10, 8'h00);
            wr(8'h11, 8'h10);
            wait_conv;
            adc_result = 16'h1100;
            wait_conv;
            cur_acc(16'h1000, 16'h0011);
            repeat (NOFF - 2) wait_conv;
            adc_result = 16'h0200;
            st(0, 0, 0, 0, 8'h00);
            chk("offset_sel", 8'h01, {7'h00, offset_sel});
            wait_conv;
            cur_acc(16'h1000, 16'h0018);
            chk("offset_sel", 8'h00, {7'h00, offset_sel});
            adc_result = 16'h2601;
            wait_conv;
            cur_acc(16'h2401, 16'h001A);
            st(1, 0, 0, 0, 8'h0E);
            st(0, 1, 0, 0, 8'h00);
            adc_result = 16'h0355;
            wait_conv;
            st(0, 1, 0, 0, 8'h00);
            chk("latched", 8'h01, rd_data);
            st(0, 0, 0, 1, 8'h00);
            rd(8'h0F);
            chk("live", 8'h55, hi);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    initial begin
        rst_n = 1'b0;
        adc_result = 16'h0000;
        supply_low = 1'b0;
        bus_line_in = 1'b1;
        pin_pull = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_regs;
        t_pin;
        t_sleep;
        t_conv;
        tally_and_finish;
    end
endmodule
